// file: fsp_map.svh
// register-free constant map for the flash status polling host controller
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_DQ_W 16
`define FSP_ADDR_W 26
`define FSP_BIT_POLL 3
`define FSP_BIT_TOGGLE 6
`define FSP_BIT_TIMEOUT 5
`define FSP_BIT_SECTOR_TOGGLE 2
`define FSP_BIT_DATA_POLL 7
`define FSP_CMD_RESET 16'h00f0
`define FSP_ADDR_ANY 26'h000_0000
`define FSP_CYC_W 4
`define FSP_READ_CYC 4'ha
`define FSP_WRITE_CYC 4'h8
`define FSP_CYC_ZERO 4'h0
`define FSP_CYC_ONE 4'h1
`define FSP_CNT_W 24
`define FSP_CNT_ZERO 24'h00_0000
`define FSP_CNT_ONE 24'h00_0001
`endif

// file: fsp_pkg.sv
// types shared by the flash status polling host controller
package fsp_pkg;
  // polling algorithm selected by the user
  typedef enum logic {
    FSP_ALG_TOGGLE = 1'b0,
    FSP_ALG_DATA = 1'b1
  } fsp_alg_t;
  // bus cycle kinds requested of the pin engine
  typedef enum logic {
    FSP_CYC_READ = 1'b0,
    FSP_CYC_WRITE = 1'b1
  } fsp_cyc_t;
  // outcome of a polling run
  typedef enum logic [1:0] {
    FSP_RES_PASS = 2'b00,
    FSP_RES_FAIL = 2'b01,
    FSP_RES_TIMEOUT = 2'b10,
    FSP_RES_ABORT = 2'b11
  } fsp_res_t;
  // polling sequencer states, gray along first read, second read, check
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b000,
    FSP_RD_A = 3'b001,
    FSP_RD_B = 3'b011,
    FSP_EVAL = 3'b010,
    FSP_RESET = 3'b110,
    FSP_DONE = 3'b111
  } fsp_state_t;
endpackage

// file: fsp_bus_cycle.sv
// asynchronous flash bus cycle engine: one read or write per request
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_bus_cycle (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire fsp_pkg::fsp_cyc_t kind_in,
  input wire logic [`FSP_ADDR_W-1:0] addr_in,
  input wire logic [`FSP_DQ_W-1:0] wdata_in,
  input wire logic [`FSP_DQ_W-1:0] dq_in,
  output logic done_out,
  output logic [`FSP_DQ_W-1:0] rdata_out,
  output logic [`FSP_ADDR_W-1:0] addr_out,
  output logic [`FSP_DQ_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out
);
  logic [`FSP_CYC_W-1:0] cnt_r;
  logic busy_r;
  logic is_wr_r;

  // cycle length counter; strobes fall at start and rise at the last count
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      cnt_r <= `FSP_CYC_ZERO;
      is_wr_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (!busy_r && req_in) begin
        busy_r <= 1'b1;
        is_wr_r <= (kind_in == fsp_pkg::FSP_CYC_WRITE);
        cnt_r <= (kind_in == fsp_pkg::FSP_CYC_WRITE) ? `FSP_WRITE_CYC : `FSP_READ_CYC;
      end else if (busy_r) begin
        cnt_r <= cnt_r - `FSP_CYC_ONE;
        if (cnt_r == `FSP_CYC_ONE) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

  // pins: chip enable and the strobe low for the whole cycle, data held
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      addr_out <= `FSP_ADDR_ANY;
      dq_out <= `FSP_CMD_RESET;
      dq_oe_n_out <= 1'b1;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      rdata_out <= `FSP_CMD_RESET;
    end else if (!busy_r && req_in) begin
      addr_out <= addr_in;
      dq_out <= wdata_in;
      dq_oe_n_out <= (kind_in != fsp_pkg::FSP_CYC_WRITE);
      ce_n_out <= 1'b0;
      oe_n_out <= (kind_in == fsp_pkg::FSP_CYC_WRITE);
      we_n_out <= (kind_in != fsp_pkg::FSP_CYC_WRITE);
    end else if (busy_r && cnt_r == `FSP_CYC_ONE) begin
      // sample at the end of the access; data bus released on the same edge
      if (!is_wr_r) begin
        rdata_out <= dq_in;
      end
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      dq_oe_n_out <= 1'b1;
    end
  end
endmodule

// file: fsp_poll_ctrl.sv
// host polling controller for embedded program and erase status
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_poll_ctrl (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire fsp_pkg::fsp_alg_t alg_in,
  input wire logic [`FSP_ADDR_W-1:0] poll_addr_in,
  input wire logic [`FSP_DQ_W-1:0] expect_in,
  input wire logic [`FSP_CNT_W-1:0] max_reads_in,
  input wire logic abort_in,
  input wire logic [`FSP_DQ_W-1:0] dq_in,
  output logic [`FSP_ADDR_W-1:0] addr_out,
  output logic [`FSP_DQ_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic busy_out,
  output logic done_out,
  output fsp_pkg::fsp_res_t result_out,
  output logic erase_suspended_out,
  output logic sector_erasing_out,
  output logic [`FSP_CNT_W-1:0] reads_out
);
  fsp_pkg::fsp_state_t state_r;
  fsp_pkg::fsp_state_t state_nxt;
  fsp_pkg::fsp_alg_t alg_r;
  logic [`FSP_ADDR_W-1:0] valid_poll_address_r;
  logic expect_b7_r;
  logic [`FSP_CNT_W-1:0] max_r;
  logic [`FSP_DQ_W-1:0] first_r;
  logic timeout_seen_r;
  logic cyc_req_r;
  fsp_pkg::fsp_cyc_t cyc_kind_r;
  logic cyc_done;
  logic [`FSP_DQ_W-1:0] cyc_data;
  logic [`FSP_CNT_W-1:0] reads_r;

  // bit extractor used by both polling algorithms
  function automatic logic dq_bit(input logic [`FSP_DQ_W-1:0] w, input int idx);
    dq_bit = w[idx];
  endfunction

  // whether one bit differs between the two latest status reads
  function automatic logic toggled(input logic [`FSP_DQ_W-1:0] a,
                                   input logic [`FSP_DQ_W-1:0] b,
                                   input int idx);
    toggled = dq_bit(a, idx) ^ dq_bit(b, idx);
  endfunction

  fsp_bus_cycle u_cycle (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .req_in(cyc_req_r),
    .kind_in(cyc_kind_r),
    .addr_in(valid_poll_address_r),
    .wdata_in(`FSP_CMD_RESET),
    .dq_in(dq_in),
    .done_out(cyc_done),
    .rdata_out(cyc_data),
    .addr_out(addr_out),
    .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out),
    .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out),
    .we_n_out(we_n_out)
  );

  // next state; abort leaves the loop and a later start restarts it whole
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fsp_pkg::FSP_IDLE: begin
        if (start_in) begin
          state_nxt = fsp_pkg::FSP_RD_A;
        end
      end
      fsp_pkg::FSP_RD_A: begin
        // abort waits out a read in flight so the engine is idle for the next run
        if (abort_in && (cyc_done || (ce_n_out && !cyc_req_r))) begin
          state_nxt = fsp_pkg::FSP_DONE;
        end else if (cyc_done) begin
          state_nxt = fsp_pkg::FSP_RD_B;
        end
      end
      fsp_pkg::FSP_RD_B: begin
        if (abort_in && (cyc_done || (ce_n_out && !cyc_req_r))) begin
          state_nxt = fsp_pkg::FSP_DONE;
        end else if (cyc_done) begin
          state_nxt = fsp_pkg::FSP_EVAL;
        end
      end
      fsp_pkg::FSP_EVAL: begin
        state_nxt = fsp_pkg::FSP_RD_B;
        if (alg_r == fsp_pkg::FSP_ALG_TOGGLE) begin
          if (!toggled(first_r, cyc_data, `FSP_BIT_TOGGLE)) begin
            state_nxt = fsp_pkg::FSP_DONE;
          end else if (timeout_seen_r) begin
            state_nxt = fsp_pkg::FSP_RESET;
          end
        end else begin
          // matching bit 7 is trusted only on a fresh read
          if (dq_bit(cyc_data, `FSP_BIT_DATA_POLL) == expect_b7_r) begin
            state_nxt = fsp_pkg::FSP_DONE;
          end else if (timeout_seen_r) begin
            state_nxt = fsp_pkg::FSP_RESET;
          end
        end
        if (state_nxt == fsp_pkg::FSP_RD_B && reads_r >= max_r) begin
          state_nxt = fsp_pkg::FSP_RESET;
        end
      end
      fsp_pkg::FSP_RESET: begin
        if (cyc_done) begin
          state_nxt = fsp_pkg::FSP_DONE;
        end
      end
      fsp_pkg::FSP_DONE: begin
        state_nxt = fsp_pkg::FSP_IDLE;
      end
      default: begin
        state_nxt = fsp_pkg::FSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= fsp_pkg::FSP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latch the job; the poll address stays on the bus for every read
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      alg_r <= fsp_pkg::FSP_ALG_TOGGLE;
      valid_poll_address_r <= `FSP_ADDR_ANY;
      expect_b7_r <= 1'b0;
      max_r <= `FSP_CNT_ZERO;
    end else if (state_r == fsp_pkg::FSP_IDLE && start_in) begin
      alg_r <= alg_in;
      valid_poll_address_r <= poll_addr_in;
      expect_b7_r <= dq_bit(expect_in, `FSP_BIT_DATA_POLL);
      max_r <= max_reads_in;
    end
  end

  // bus cycle requests: one per read state, a reset write on failure
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cyc_req_r <= 1'b0;
      cyc_kind_r <= fsp_pkg::FSP_CYC_READ;
    end else begin
      cyc_req_r <= 1'b0;
      // an abort holds back new reads but never the reset write
      if (state_nxt != state_r) begin
        // every entry to reading starts a fresh cycle unless abort is high
        unique case (state_nxt)
          fsp_pkg::FSP_RD_A, fsp_pkg::FSP_RD_B: begin
            cyc_req_r <= !abort_in;
            cyc_kind_r <= fsp_pkg::FSP_CYC_READ;
          end
          fsp_pkg::FSP_RESET: begin
            cyc_req_r <= 1'b1;
            cyc_kind_r <= fsp_pkg::FSP_CYC_WRITE;
          end
          default: begin
            cyc_req_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // keep the previous read and note the timeout bit before the next compare
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      first_r <= `FSP_CMD_RESET;
      timeout_seen_r <= 1'b0;
      reads_r <= `FSP_CNT_ZERO;
    end else if (state_r == fsp_pkg::FSP_IDLE) begin
      timeout_seen_r <= 1'b0;
      reads_r <= `FSP_CNT_ZERO;
    end else if (cyc_done && state_r != fsp_pkg::FSP_RESET) begin
      reads_r <= reads_r + `FSP_CNT_ONE;
      // first of the double read kept for the compare
      if (state_r == fsp_pkg::FSP_RD_A) begin
        first_r <= cyc_data;
      end
    end else if (state_r == fsp_pkg::FSP_EVAL) begin
      first_r <= cyc_data;
      // timeout noted now, acted on only after one more read
      timeout_seen_r <= dq_bit(cyc_data, `FSP_BIT_TIMEOUT);
    end
  end

  // results; only status leaves, no polling read is passed on as data
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      result_out <= fsp_pkg::FSP_RES_PASS;
      erase_suspended_out <= 1'b0;
      sector_erasing_out <= 1'b0;
      reads_out <= `FSP_CNT_ZERO;
    end else begin
      done_out <= (state_nxt == fsp_pkg::FSP_DONE && state_r != fsp_pkg::FSP_DONE);
      busy_out <= (state_nxt != fsp_pkg::FSP_IDLE && state_nxt != fsp_pkg::FSP_DONE);
      reads_out <= reads_r;
      if (state_r == fsp_pkg::FSP_EVAL) begin
        // bit 6 still with bit 2 toggling: suspended; bit 2 toggling: sector selected
        erase_suspended_out <= !toggled(first_r, cyc_data, `FSP_BIT_TOGGLE)
                               && toggled(first_r, cyc_data, `FSP_BIT_SECTOR_TOGGLE);
        sector_erasing_out <= toggled(first_r, cyc_data, `FSP_BIT_SECTOR_TOGGLE);
        if (state_nxt == fsp_pkg::FSP_DONE) begin
          result_out <= fsp_pkg::FSP_RES_PASS;
        end else if (state_nxt == fsp_pkg::FSP_RESET) begin
          result_out <= timeout_seen_r ? fsp_pkg::FSP_RES_FAIL : fsp_pkg::FSP_RES_TIMEOUT;
        end
      end else if (abort_in && (state_r == fsp_pkg::FSP_RD_A
                                || state_r == fsp_pkg::FSP_RD_B)) begin
        result_out <= fsp_pkg::FSP_RES_ABORT;
      end
    end
  end
endmodule

// file: fsp_poll_chk.sv
// port-level assertions for the polling controller
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_poll_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [`FSP_ADDR_W-1:0] poll_addr_in,
  input wire logic [`FSP_CNT_W-1:0] max_reads_in,
  input wire logic abort_in,
  input wire logic [`FSP_DQ_W-1:0] dq_in,
  input wire logic [`FSP_ADDR_W-1:0] addr_out,
  input wire logic [`FSP_DQ_W-1:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic ce_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire fsp_pkg::fsp_res_t result_out,
  input wire logic erase_suspended_out,
  input wire logic sector_erasing_out
);
  logic [`FSP_CNT_W-1:0] rd_cnt_r;
  logic fault_r;
  logic oe_q_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // reads per run and timeout bit seen; cleared at done so each run starts clean
  always_ff @(posedge clock_in) begin
    oe_q_r <= oe_n_out;
    if (!rst_n_in || done_out) begin
      rd_cnt_r <= `FSP_CNT_ZERO;
      fault_r <= 1'b0;
    end else begin
      if (!oe_n_out && oe_q_r) rd_cnt_r <= rd_cnt_r + `FSP_CNT_ONE;
      if (!oe_n_out && dq_in[`FSP_BIT_TIMEOUT]) fault_r <= 1'b1;
    end
  end
  sequence reset_write_s;
    !we_n_out && !ce_n_out && !dq_oe_n_out && dq_out == `FSP_CMD_RESET;
  endsequence
  chk_read_addr: assert property (!oe_n_out |-> addr_out == poll_addr_in)
    else $error("status read away from poll address");
  chk_two_reads: assert property (done_out && result_out != fsp_pkg::FSP_RES_ABORT
    |-> rd_cnt_r >= 24'h00_0002) else $error("verdict before two reads");
  chk_read_budget: assert property (done_out |-> rd_cnt_r <= max_reads_in)
    else $error("read budget overrun");
  chk_fail_cause: assert property (done_out && result_out == fsp_pkg::FSP_RES_FAIL
    |-> fault_r) else $error("fail without timeout bit");
  chk_reset_cmd: assert property ($fell(we_n_out) |-> reset_write_s [*8])
    else $error("bad reset command write");
  chk_fail_resets: assert property ($rose(we_n_out) |-> ##[0:6] done_out &&
    result_out inside {fsp_pkg::FSP_RES_FAIL, fsp_pkg::FSP_RES_TIMEOUT})
    else $error("reset write without fault verdict");
  chk_abort_quiet: assert property (abort_in && busy_out |-> we_n_out)
    else $error("write during abort");
  chk_suspend_flag: assert property (erase_suspended_out |-> sector_erasing_out)
    else $error("suspend flag without sector toggle");
endmodule
bind fsp_poll_ctrl fsp_poll_chk chk_u (.clock_in, .rst_n_in, .poll_addr_in, .max_reads_in,
  .abort_in, .dq_in, .addr_out, .dq_out, .dq_oe_n_out, .ce_n_out, .oe_n_out, .we_n_out,
  .busy_out, .done_out, .result_out, .erase_suspended_out, .sector_erasing_out);

// file: fsp_flash_model.sv
// behavioural flash status outputs seen by the polling controller
`timescale 1ns/1ps
module fsp_flash_model (
  input wire logic load_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] busy_in,
  input wire logic [15:0] datum_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  output logic [15:0] dq_out,
  output logic reset_seen_out
);
  // mode 0 program, 1 erase, 2 erase suspended, 3 program past its pulse limit
  logic [7:0] left_r = 8'h00;
  logic tog_r = 1'b0;
  logic sec_r = 1'b0;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] stat_w;
  always_comb begin
    stat_w = datum_in;
    if (left_r != 8'h00 || mode_in == 2'h2) begin
      stat_w = 16'h0000;
      stat_w[7] = (mode_in[0] ^ mode_in[1]) ? mode_in[1] : ~datum_in[7];
      stat_w[6] = tog_r;
      stat_w[5] = (mode_in == 2'h3);
      stat_w[2] = (mode_in[0] ^ mode_in[1]) & sec_r;
    end
  end
  // released bus shows the inverse of the last read, never a stale copy
  assign dq_out = (oe_n_in || ce_n_in) ? ~last_r : stat_w;
  // busy from the last load pulse for busy_in reads
  always @(posedge load_in) begin
    left_r = busy_in;
    reset_seen_out = 1'b0;
  end
  // each finished read advances the sector toggle, and bit 6 only while busy; a stuck fault lasts until the reset command
  always @(posedge oe_n_in) begin
    last_r = stat_w;
    sec_r = ~sec_r;
    if (left_r != 8'h00) tog_r = ~tog_r;
    if (left_r != 8'h00 && mode_in != 2'h3) left_r = left_r - 8'h01;
  end
  // level sampled so the strobe edge and bus turnaround cannot race
  always @(dq_in or we_n_in) begin
    if (!we_n_in && dq_in == 16'h00f0) begin
      left_r = 8'h00;
      reset_seen_out = 1'b1;
    end
  end
endmodule

// file: fsp_poll_ctrl_test.sv
// self-checking bench for the polling controller against the flash model
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_poll_ctrl_test;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_r = 1'b0;
  logic abort_r = 1'b0;
  logic load_r = 1'b0;
  fsp_pkg::fsp_alg_t alg_r = fsp_pkg::FSP_ALG_TOGGLE;
  logic [1:0] mode_r = 2'h0;
  logic [7:0] busy_r = 8'h00;
  logic [15:0] datum_r = 16'h0000;
  logic [23:0] maxr_r = 24'h00_00c8;
  logic [15:0] host_dq_w, mdl_dq_w, bus_w;
  logic dq_oe_n_w, ce_n_w, oe_n_w, we_n_w, done_w, susp_w, sect_w, seen_w, busy_w;
  fsp_pkg::fsp_res_t res_w;
  logic [23:0] reads_w;
  logic [25:0] addr_w;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  // host drives the bus only while its enable is low
  assign bus_w = dq_oe_n_w ? mdl_dq_w : host_dq_w;
  always #2 clock_in = ~clock_in;
  fsp_poll_ctrl dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_r),
    .alg_in(alg_r), .poll_addr_in(26'h000_1234), .expect_in(datum_r),
    .max_reads_in(maxr_r), .abort_in(abort_r), .dq_in(bus_w), .addr_out(addr_w),
    .dq_out(host_dq_w), .dq_oe_n_out(dq_oe_n_w), .ce_n_out(ce_n_w), .oe_n_out(oe_n_w),
    .we_n_out(we_n_w), .busy_out(busy_w), .done_out(done_w), .result_out(res_w),
    .erase_suspended_out(susp_w), .sector_erasing_out(sect_w), .reads_out(reads_w));
  fsp_flash_model flash_u (.load_in(load_r), .mode_in(mode_r), .busy_in(busy_r),
    .datum_in(datum_r), .dq_in(bus_w), .ce_n_in(ce_n_w), .oe_n_in(oe_n_w),
    .we_n_in(we_n_w), .dq_out(mdl_dq_w), .reset_seen_out(seen_w));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hung run is cut off well past the longest expected sequence
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one polling run against a freshly loaded operation, abort after abort_at cycles
  task automatic poll(input fsp_pkg::fsp_alg_t alg, input logic [1:0] mode,
      input logic [7:0] busy, input logic [15:0] datum, input int abort_at);
    int n;
    n = 0;
    @(posedge clock_in);
    #1;
    alg_r = alg;
    mode_r = mode;
    busy_r = busy;
    datum_r = datum;
    load_r = 1'b1;
    start_r = 1'b1;
    @(posedge clock_in);
    #1;
    load_r = 1'b0;
    start_r = 1'b0;
    check(busy_w, 1'b1);
    while (done_w !== 1'b1) begin
      @(posedge clock_in);
      #1;
      n++;
      if (n == abort_at) abort_r = 1'b1;
    end
    abort_r = 1'b0;
    check(busy_w, 1'b0);
    check(addr_w === 26'h000_1234, 1'b1);
  endtask
  task automatic t_toggle_prog;
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h0, 8'h03, 16'h0055, 0);
    check(res_w, fsp_pkg::FSP_RES_PASS);
    check(seen_w, 1'b0);
    $display("toggle program finished");
  endtask
  task automatic t_data_prog;
    for (int i = 0; i < 2; i++) begin
      poll(fsp_pkg::FSP_ALG_DATA, 2'h0, 8'h04, i ? 16'h00aa : 16'h0055, 0);
      check(res_w, fsp_pkg::FSP_RES_PASS);
    end
    $display("data poll program finished");
  endtask
  task automatic t_erase;
    poll(fsp_pkg::FSP_ALG_DATA, 2'h1, 8'h04, 16'h00ff, 0);
    check(res_w, fsp_pkg::FSP_RES_PASS);
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h1, 8'h04, 16'h00ff, 0);
    check(res_w, fsp_pkg::FSP_RES_PASS);
    $display("erase finished");
  endtask
  task automatic t_suspend;
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h2, 8'h00, 16'h00ff, 0);
    check(res_w, fsp_pkg::FSP_RES_PASS);
    check({susp_w, sect_w}, 2'b11);
    $display("suspend finished");
  endtask
  task automatic t_fault;
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h3, 8'h01, 16'h0055, 0);
    check(res_w, fsp_pkg::FSP_RES_FAIL);
    check(seen_w, 1'b1);
    $display("fault finished");
  endtask
  task automatic t_budget;
    maxr_r = 24'h00_0008;
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h0, 8'hff, 16'h0055, 0);
    check(res_w, fsp_pkg::FSP_RES_TIMEOUT);
    check(seen_w, 1'b1);
    @(posedge clock_in);
    #1;
    check(reads_w, 24'h00_0008);
    maxr_r = 24'h00_00c8;
    $display("budget finished");
  endtask
  task automatic t_abort;
    poll(fsp_pkg::FSP_ALG_TOGGLE, 2'h0, 8'hff, 16'h0055, 30);
    check(res_w, fsp_pkg::FSP_RES_ABORT);
    check(seen_w, 1'b0);
    $display("abort finished");
  endtask
  // main sequence: reset, then every scenario back to back
  initial begin
    repeat (8) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    t_toggle_prog;
    t_data_prog;
    t_erase;
    t_suspend;
    t_fault;
    t_budget;
    t_abort;
    end_of_test;
  end
endmodule
